// ===== eps_enclave_perfmon.sv
// Summary of operation
// - Status bit 60 flags enclave interference
// - Flag clear means counters count normally
// - Opt-in entry changes nothing, flag stays clear
// - Opt-out entry suppresses thread monitoring except cycles
// - Opt-out stops fixed zero, general; sets flag
// - Opt-out suppresses sampling records
// - Opt-out demotes sibling any-thread counters
// - Exit or async exit resumes monitoring
// - Exit restores sibling any-thread counting
// - Supervisor leaves report own address
// - Key and report leaves report own address
// - Entry: opt-in reports address, opt-out none
// - Exit record: opt-in reports exit address
// - Async exit record: saved ip or entry address
// - Second record after exiting event reports pointer
// - Record store fault reported, record skipped
// - Async exit faults dropped, record aborted
// - Async exit traps pend until instruction boundary
// - Exiting event delivery continues after abort
// - Opt-in transitions count as far branches
// - Opt-out session counts one branch, one instruction
// - Shared counters unaffected by entry
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module eps_enclave_perfmon #(
  parameter int IPW  = 64,
  parameter int NGP  = 4,
  parameter int NSIB = 7
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Register port
  input  wire logic [7:0]      regAddr,
  input  wire logic [63:0]     regWdata,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic      [63:0]     regRdata,
  // Retirement from the core
  input  wire logic            retValid,
  input  wire logic [2:0]      retKind,
  input  wire logic [IPW-1:0]  retIp,
  input  wire logic            entryOptIn,
  input  wire logic [IPW-1:0]  ssaIp,
  input  wire logic [IPW-1:0]  aepIp,
  input  wire logic            pebsPending,
  // Exiting event delivery
  input  wire logic            eeeDelivered,
  input  wire logic            eeePebsPending,
  output logic                 eeeProceed,
  // Record writer feedback
  input  wire logic            recDone,
  input  wire logic            recFaultLike,
  input  wire logic            recTrapLike,
  input  wire logic            instrBoundary,
  // Record request
  output logic                 recValid,
  output logic      [IPW-1:0]  recIp,
  output logic                 recSynthetic,
  output logic                 faultReport,
  output logic                 trapRelease,
  // Counter controls
  output logic      [2:0]      fixedCtrEn,
  output logic      [NGP-1:0]  gpCtrEn,
  output logic      [NSIB-1:0] siblingAnyThread,
  output logic                 pebsActive,
  output logic                 sharedCtrEn,
  output logic                 branchInc,
  output logic                 instrInc
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                 inEnclave_q;
  logic                 optIn_q;
  logic                 sciFlag_q;
  logic                 trapPend_q;
  logic [63:0]          config_q;
  logic [63:0]          count_any_thread_q;
  eps_pkg::eps_rec_t    recState_q;
  eps_pkg::eps_rec_t    recState_d;
  logic [IPW-1:0]       entryIpStored;
  logic                 suppress;
  logic                 pebsCfg;
  logic                 isEntry;
  logic                 isExit;
  logic                 isAex;
  logic                 leaving;
  logic                 statusClr;
  logic                 reqFire;
  logic [IPW-1:0]       reqIp;
  logic                 reqAex;
  logic                 recEnd;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // True when a retirement of the given kind occurs
  function automatic logic retIs(input logic v, input logic [2:0] k, input logic [2:0] want);
    retIs = v && (k == want);
  endfunction

  // Address seen by a record at session end
  function automatic logic [IPW-1:0] sessionIp(input logic optIn, input logic [IPW-1:0] inIp,
                                                input logic [IPW-1:0] entIp);
    sessionIp = optIn ? inIp : entIp;
  endfunction

  assign isEntry = retIs(retValid, retKind, eps_pkg::RET_ENTER) ||
                   retIs(retValid, retKind, eps_pkg::RET_RESUME);
  assign isExit  = retIs(retValid, retKind, eps_pkg::RET_EXIT);
  assign isAex   = retIs(retValid, retKind, eps_pkg::RET_AEX);
  assign leaving = (isExit || isAex) && inEnclave_q;
  assign pebsCfg = config_q[eps_pkg::CFG_PRECISE_EVENT_SAMPLING_BIT];

  // ----------------------------------------
  // Enclave session state
  // ----------------------------------------
  // Mode kept per thread for the whole session
  always_ff @(posedge clk) begin
    if (rst) begin
      inEnclave_q <= 1'b0;
      optIn_q     <= 1'b0;
    end else if (isEntry) begin
      inEnclave_q <= 1'b1;
      optIn_q     <= entryOptIn;
    end else if (isExit || isAex) begin
      inEnclave_q <= 1'b0;
    end
  end

  // Entry address, needed for opt-out records later
  eps_ip_store #(
    .WIDTH (IPW),
    .DEPTH (2)
  ) u_ipStore (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (isEntry),
    .wrAddr (eps_pkg::SLOT_ENTRY),
    .wrData (retIp),
    .rdAddr (eps_pkg::SLOT_ENTRY),
    .rdData (entryIpStored)
  );

  // Only opt-out sessions alter monitoring
  assign suppress = inEnclave_q && !optIn_q;

  // ----------------------------------------
  // Counter gating
  // ----------------------------------------
  // Cycle counters one and two never stop
  assign fixedCtrEn[0] = !suppress;
  assign fixedCtrEn[1] = 1'b1;
  assign fixedCtrEn[2] = 1'b1;
  assign gpCtrEn       = {NGP{!suppress}};
  assign pebsActive    = pebsCfg && !suppress;

  // Sibling any-thread bits masked, config itself kept
  assign siblingAnyThread = count_any_thread_q[NSIB-1:0] & {NSIB{!suppress}};

  // Cross-core counters are never gated here
  assign sharedCtrEn = 1'b1;

  // ----------------------------------------
  // Interference flag
  // ----------------------------------------
  assign statusClr = regWr && (regAddr == eps_pkg::ADDR_STATUS_CLR) &&
                     regWdata[eps_pkg::SCI_FLAG_BIT];

  // A set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      sciFlag_q <= 1'b0;
    end else if (isEntry && !entryOptIn) begin
      sciFlag_q <= 1'b1;
    end else if (statusClr) begin
      sciFlag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q <= eps_pkg::RST_CONFIG;
    end else if (regWr && regAddr == eps_pkg::ADDR_CONFIG) begin
      config_q <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_any_thread_q <= eps_pkg::RST_ANY_THREAD;
    end else if (regWr && regAddr == eps_pkg::ADDR_ANY_THREAD) begin
      count_any_thread_q <= regWdata;
    end
  end

  // ----------------------------------------
  // Register read, data one cycle later
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        eps_pkg::ADDR_STATUS: begin
          regRdata <= '0;
          regRdata[eps_pkg::SCI_FLAG_BIT] <= sciFlag_q;
        end
        eps_pkg::ADDR_CONFIG:     regRdata <= config_q;
        eps_pkg::ADDR_ANY_THREAD: regRdata <= count_any_thread_q;
        eps_pkg::ADDR_SESSION: begin
          regRdata <= '0;
          regRdata[eps_pkg::SES_IN_BIT]    <= inEnclave_q;
          regRdata[eps_pkg::SES_OPTIN_BIT] <= optIn_q;
          regRdata[eps_pkg::SES_TRAP_BIT]  <= trapPend_q;
          regRdata[eps_pkg::SES_REC_BIT]   <= (recState_q != eps_pkg::REC_IDLE);
        end
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------
  // Record request selection
  // ----------------------------------------
  // Picks the reported address per retirement kind
  always_comb begin
    reqFire = 1'b0;
    reqIp   = retIp;
    reqAex  = 1'b0;
    if (eeeDelivered && eeePebsPending && pebsCfg) begin
      reqFire = 1'b1;
      reqIp   = aepIp;
    end else if (retValid && pebsPending && pebsCfg) begin
      unique case (retKind)
        eps_pkg::RET_SUPER: reqFire = !suppress;
        eps_pkg::RET_KEY,
        eps_pkg::RET_REPORT: reqFire = !suppress;
        eps_pkg::RET_ENTER,
        eps_pkg::RET_RESUME: reqFire = entryOptIn;
        eps_pkg::RET_EXIT: begin
          reqFire = 1'b1;
          reqIp   = sessionIp(optIn_q, retIp, entryIpStored);
        end
        eps_pkg::RET_AEX: begin
          reqFire = 1'b1;
          reqAex  = 1'b1;
          reqIp   = sessionIp(optIn_q, ssaIp, entryIpStored);
        end
        default: reqFire = !suppress;
      endcase
    end
  end

  // ----------------------------------------
  // Record writer state
  // ----------------------------------------
  // A new request is taken only when idle
  always_comb begin
    recState_d = recState_q;
    recEnd     = 1'b0;
    unique case (recState_q)
      eps_pkg::REC_IDLE: begin
        if (reqFire) begin
          recState_d = reqAex ? eps_pkg::REC_AEX : eps_pkg::REC_BUSY;
        end
      end
      eps_pkg::REC_BUSY: begin
        if (recDone || recFaultLike) begin
          recState_d = eps_pkg::REC_IDLE;
        end
      end
      eps_pkg::REC_AEX: begin
        if (recDone || recFaultLike) begin
          recState_d = eps_pkg::REC_IDLE;
          recEnd     = 1'b1;
        end
      end
      default: recState_d = eps_pkg::REC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      recState_q <= eps_pkg::REC_IDLE;
    end else begin
      recState_q <= recState_d;
    end
  end

  // Request pulse with its address
  always_ff @(posedge clk) begin
    if (rst) begin
      recValid     <= 1'b0;
      recIp        <= '0;
      recSynthetic <= 1'b0;
    end else begin
      recValid <= reqFire && (recState_q == eps_pkg::REC_IDLE);
      if (reqFire && (recState_q == eps_pkg::REC_IDLE)) begin
        recIp        <= reqIp;
        recSynthetic <= reqAex;
      end
    end
  end

  // ----------------------------------------
  // Fault and trap handling
  // ----------------------------------------
  // Faults outside the exit window go straight out
  always_ff @(posedge clk) begin
    if (rst) begin
      faultReport <= 1'b0;
    end else begin
      faultReport <= (recState_q == eps_pkg::REC_BUSY) && recFaultLike;
    end
  end

  // No event window at exit end, so traps wait
  always_ff @(posedge clk) begin
    if (rst) begin
      trapPend_q <= 1'b0;
    end else if (recState_q == eps_pkg::REC_AEX && recTrapLike) begin
      trapPend_q <= 1'b1;
    end else if (instrBoundary) begin
      trapPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trapRelease <= 1'b0;
    end else begin
      trapRelease <= trapPend_q && instrBoundary;
    end
  end

  // Exiting event goes on once the async record ends or aborts, or at once when no record was taken
  always_ff @(posedge clk) begin
    if (rst) begin
      eeeProceed <= 1'b0;
    end else begin
      eeeProceed <= recEnd || (isAex && !(reqFire && recState_q == eps_pkg::REC_IDLE));
    end
  end

  // ----------------------------------------
  // Branch and instruction counting
  // ----------------------------------------
  // Opt-out session collapses to one branch at exit
  always_ff @(posedge clk) begin
    if (rst) begin
      branchInc <= 1'b0;
      instrInc  <= 1'b0;
    end else begin
      branchInc <= (isEntry && entryOptIn) || leaving;
      instrInc  <= (isEntry && entryOptIn) || leaving;
    end
  end

endmodule

`default_nettype wire

// ===== eps_pkg.sv
package eps_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_STATUS_CLR = 8'h08;
  localparam logic [7:0] ADDR_CONFIG     = 8'h10;
  localparam logic [7:0] ADDR_ANY_THREAD = 8'h18;
  localparam logic [7:0] ADDR_SESSION    = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SCI_FLAG_BIT   = 60;
  localparam int CFG_PRECISE_EVENT_SAMPLING_BIT   = 0;
  localparam int SES_IN_BIT     = 0;
  localparam int SES_OPTIN_BIT  = 1;
  localparam int SES_TRAP_BIT   = 2;
  localparam int SES_REC_BIT    = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [63:0] RST_CONFIG     = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_ANY_THREAD = 64'h0000_0000_0000_0000;

  // ----------------------------------------
  // Retirement kinds reported by the core
  // ----------------------------------------
  localparam logic [2:0] RET_OTHER  = 3'h0;
  localparam logic [2:0] RET_SUPER  = 3'h1;
  localparam logic [2:0] RET_KEY    = 3'h2;
  localparam logic [2:0] RET_REPORT = 3'h3;
  localparam logic [2:0] RET_ENTER  = 3'h4;
  localparam logic [2:0] RET_RESUME = 3'h5;
  localparam logic [2:0] RET_EXIT   = 3'h6;
  localparam logic [2:0] RET_AEX    = 3'h7;

  // ----------------------------------------
  // Address store slots
  // ----------------------------------------
  localparam logic SLOT_ENTRY = 1'b0;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_BUSY = 3'b010,
    REC_AEX  = 3'b100
  } eps_rec_t;

endpackage

// ===== eps_ip_store.sv
`timescale 1ns/100ps
`default_nettype none

module eps_ip_store #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  // Read port, data one cycle later
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------
  // Storage, no reset needed on contents
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read keeps the output glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

`default_nettype wire

// ===== eps_perfmon_chk.sv
`timescale 1ns/100ps
`default_nettype none
module eps_perfmon_chk #(
  parameter int IPW  = 64,
  parameter int NGP  = 4,
  parameter int NSIB = 7
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // Core and writer inputs
  input wire logic            retValid,
  input wire logic [2:0]      retKind,
  input wire logic [IPW-1:0]  retIp,
  input wire logic            entryOptIn,
  input wire logic [IPW-1:0]  ssaIp,
  input wire logic [IPW-1:0]  aepIp,
  input wire logic            pebsPending,
  input wire logic            eeeDelivered,
  input wire logic            eeePebsPending,
  input wire logic            recDone,
  input wire logic            recFaultLike,
  input wire logic            recTrapLike,
  input wire logic            instrBoundary,
  // Block outputs
  input wire logic            eeeProceed,
  input wire logic            recValid,
  input wire logic [IPW-1:0]  recIp,
  input wire logic            recSynthetic,
  input wire logic            faultReport,
  input wire logic            trapRelease,
  input wire logic [2:0]      fixedCtrEn,
  input wire logic [NGP-1:0]  gpCtrEn,
  input wire logic [NSIB-1:0] siblingAnyThread,
  input wire logic            pebsActive,
  input wire logic            sharedCtrEn,
  input wire logic            branchInc,
  input wire logic            instrInc
);
  // ----
  // Shadow of session and writer state
  // ----
  logic optOut_q;
  logic busy_q;
  logic aex_q;
  logic trap_q;
  wire logic isEnt  = retValid && retKind inside {eps_pkg::RET_ENTER, eps_pkg::RET_RESUME};
  wire logic isExit = retValid && retKind inside {eps_pkg::RET_EXIT, eps_pkg::RET_AEX};

  // Session kind, kept only from retirements
  always_ff @(posedge clk) begin
    if (rst || isExit) optOut_q <= 1'b0;
    else if (isEnt) optOut_q <= !entryOptIn;
  end

  // One record outstanding; async flavour noted
  always_ff @(posedge clk) begin
    if (rst || recDone || recFaultLike) begin
      busy_q <= 1'b0;
      aex_q  <= 1'b0;
    end else if (recValid) begin
      busy_q <= 1'b1;
      aex_q  <= recSynthetic;
    end
  end

  // Trap seen during an async record
  always_ff @(posedge clk) begin
    if (rst || instrBoundary) trap_q <= 1'b0;
    else if (recTrapLike && aex_q) trap_q <= 1'b1;
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sOwnIp;
    retValid && pebsPending && pebsActive && !busy_q && !eeeDelivered &&
    (retKind inside {[eps_pkg::RET_SUPER:eps_pkg::RET_REPORT]} || (isEnt && entryOptIn) ||
     (retKind == eps_pkg::RET_EXIT && !optOut_q));
  endsequence
  sequence sRec(logic [IPW-1:0] ip);
    recValid && recIp == ip;
  endsequence
  sequence sOneCount;
    branchInc && instrInc ##1 !branchInc && !instrInc;
  endsequence

  chk_gate_ctrs: assert property (gpCtrEn == {NGP{!optOut_q}} && fixedCtrEn == {2'b11, !optOut_q})
    else $error("counter enables wrong for session");
  chk_sib_demote: assert property (optOut_q |-> siblingAnyThread == '0)
    else $error("sibling any-thread not demoted");
  chk_precise_event_sampling_quiet: assert property (optOut_q |-> !pebsActive && !recValid)
    else $error("sampling active in opt-out session");
  chk_shared_on: assert property (sharedCtrEn)
    else $error("shared counters gated");
  chk_own_ip: assert property (sOwnIp |=> sRec($past(retIp)))
    else $error("record ip not instruction address");
  chk_aex_ip: assert property (retValid && retKind == eps_pkg::RET_AEX && pebsPending && pebsActive &&
    !busy_q && !optOut_q |=> recValid && recSynthetic && recIp == $past(ssaIp))
    else $error("async exit record wrong");
  chk_aep_ip: assert property (eeeDelivered && eeePebsPending && pebsActive && !busy_q |=> sRec($past(aepIp)))
    else $error("second record ip wrong");
  chk_fault_rep: assert property (recFaultLike && busy_q && !aex_q |=> faultReport)
    else $error("store fault not reported");
  chk_aex_fault: assert property (recFaultLike && aex_q |=> !faultReport && eeeProceed)
    else $error("async fault handling wrong");
  chk_trap_pend: assert property (instrBoundary && trap_q |=> trapRelease)
    else $error("pended trap not released");
  chk_optin_br: assert property ((isEnt && entryOptIn || isExit) && !optOut_q |=> sOneCount)
    else $error("opt-in transition not counted once");
  chk_optout_br: assert property (isExit && optOut_q |=> sOneCount)
    else $error("opt-out session not counted once");
  chk_optout_ent: assert property (isEnt && !entryOptIn |=> !branchInc && !instrInc)
    else $error("opt-out entry counted");
endmodule

bind eps_enclave_perfmon eps_perfmon_chk #(.IPW(IPW), .NGP(NGP), .NSIB(NSIB)) i_chk (
  .clk, .rst, .retValid, .retKind, .retIp, .entryOptIn, .ssaIp, .aepIp, .pebsPending,
  .eeeDelivered, .eeePebsPending, .recDone, .recFaultLike, .recTrapLike, .instrBoundary,
  .eeeProceed, .recValid, .recIp, .recSynthetic, .faultReport, .trapRelease, .fixedCtrEn,
  .gpCtrEn, .siblingAnyThread, .pebsActive, .sharedCtrEn, .branchInc, .instrInc
);
`default_nettype wire

// ===== eps_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module eps_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // From the block
  input  wire logic recValid,
  input  wire logic recSynthetic,
  input  wire logic eeeProceed,
  // Bench controls
  input  wire logic faultMode,
  input  wire logic slow,
  // Answers
  output logic      recDone,
  output logic      recFaultLike,
  output logic      recTrapLike,
  output logic      eeeDelivered,
  output logic      eeePebsPending,
  output logic      instrBoundary
);
  logic [2:0] recCnt_q;
  logic [2:0] eeeCnt_q;
  logic       syn_q;

  // Record writer; slow answers leave room for a trap first
  always_ff @(posedge clk) begin
    recDone      <= 1'b0;
    recFaultLike <= 1'b0;
    recTrapLike  <= 1'b0;
    if (rst) begin
      recCnt_q <= 3'h0;
      syn_q    <= 1'b0;
    end else if (recValid) begin
      recCnt_q <= slow ? 3'h4 : 3'h1;
      syn_q    <= recSynthetic;
    end else if (recCnt_q != 3'h0) begin
      recCnt_q     <= recCnt_q - 3'h1;
      recTrapLike  <= syn_q && recCnt_q == 3'h2;
      recFaultLike <= recCnt_q == 3'h1 && (syn_q || faultMode);
      recDone      <= recCnt_q == 3'h1 && !(syn_q || faultMode);
    end
  end

  // Exiting event finishes, second event pended, then a boundary
  always_ff @(posedge clk) begin
    eeeDelivered   <= 1'b0;
    eeePebsPending <= 1'b0;
    instrBoundary  <= 1'b0;
    if (rst) eeeCnt_q <= 3'h0;
    else if (eeeProceed) eeeCnt_q <= 3'h5;
    else if (eeeCnt_q != 3'h0) begin
      eeeCnt_q       <= eeeCnt_q - 3'h1;
      eeeDelivered   <= eeeCnt_q == 3'h4;
      eeePebsPending <= eeeCnt_q == 3'h4;
      instrBoundary  <= eeeCnt_q == 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int IPW  = 64;
  localparam int NGP  = 4;
  localparam int NSIB = 7;
  logic clk, rst, regWr, regRd, retValid, entryOptIn, pebsPending, eeeDelivered, eeePebsPending;
  logic recDone, recFaultLike, recTrapLike, instrBoundary, eeeProceed, recValid, recSynthetic;
  logic faultReport, trapRelease, pebsActive, sharedCtrEn, branchInc, instrInc, faultMode, slow, rdPrev, oi;
  logic [7:0]      regAddr;
  logic [63:0]     regWdata, regRdata, retIp, ssaIp, aepIp, recIp, entIp, a, b, c;
  logic [2:0]      retKind, fixedCtrEn, k;
  logic [NGP-1:0]  gpCtrEn;
  logic [NSIB-1:0] siblingAnyThread, sibCfg;
  logic [64:0]     expRec[$];
  logic [63:0]     expRd[$];
  int              bad_count, checks_done, seed;

  eps_enclave_perfmon #(.IPW(IPW), .NGP(NGP), .NSIB(NSIB)) i_dut (
    .clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .retValid, .retKind, .retIp,
    .entryOptIn, .ssaIp, .aepIp, .pebsPending, .eeeDelivered, .eeePebsPending, .eeeProceed,
    .recDone, .recFaultLike, .recTrapLike, .instrBoundary, .recValid, .recIp, .recSynthetic,
    .faultReport, .trapRelease, .fixedCtrEn, .gpCtrEn, .siblingAnyThread, .pebsActive,
    .sharedCtrEn, .branchInc, .instrInc);
  eps_core_model i_core (
    .clk, .rst, .recValid, .recSynthetic, .eeeProceed, .faultMode, .slow, .recDone,
    .recFaultLike, .recTrapLike, .eeeDelivered, .eeePebsPending, .instrBoundary);

  // ----
  // Clock, comparison and closing
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Results are matched against the oldest note
  always @(posedge clk) begin
    if (rdPrev) check({1'b0, regRdata}, {1'b0, expRd.pop_front()});
    if (recValid && expRec.size() == 0) check(65'h1, 65'h0);
    else if (recValid) check({recSynthetic, recIp}, expRec.pop_front());
    rdPrev <= regRd;
  end

  // ----
  // Drivers
  // ----
  task wr(input logic [7:0] ad, input logic [63:0] d);
    @(posedge clk);
    regWr <= 1'b1; regAddr <= ad; regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [63:0] e);
    @(posedge clk);
    regRd <= 1'b1; regAddr <= ad; expRd.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // Idle long enough for the writer and the exiting event to settle
  task ret(input logic [2:0] kd, input logic [63:0] ip, input logic optIn);
    @(posedge clk);
    retValid <= 1'b1; retKind <= kd; retIp <= ip; entryOptIn <= optIn; pebsPending <= 1'b1;
    @(posedge clk);
    retValid <= 1'b0; pebsPending <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  task gate(input logic oo);
    #1;
    check(65'({fixedCtrEn, gpCtrEn, siblingAnyThread, pebsActive}),
          65'({2'b11, !oo, {NGP{!oo}}, oo ? {NSIB{1'b0}} : sibCfg, !oo}));
  endtask
  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction

  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end

  // ----
  // Scenarios
  // ----
  initial begin
    {regWr, regRd, retValid, entryOptIn, pebsPending, faultMode, slow, rdPrev} = '0;
    {regAddr, regWdata, retIp, ssaIp, aepIp, retKind} = '0;
    bad_count = 0;
    checks_done = 0;
    rst = 1'b1;
    seed = $urandom(32'ha40d_ad49);
    sibCfg = NSIB'($urandom) | NSIB'(1);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place, read-only status
    rd(eps_pkg::ADDR_CONFIG, eps_pkg::RST_CONFIG);
    rd(eps_pkg::ADDR_ANY_THREAD, eps_pkg::RST_ANY_THREAD);
    wr(8'h28, '1);
    rd(8'h28, 64'h0);
    wr(eps_pkg::ADDR_STATUS, 64'h1 << eps_pkg::SCI_FLAG_BIT);
    rd(eps_pkg::ADDR_STATUS, 64'h0);
    wr(eps_pkg::ADDR_CONFIG, 64'h1);
    wr(eps_pkg::ADDR_ANY_THREAD, 64'(sibCfg));
    rd(eps_pkg::ADDR_ANY_THREAD, 64'(sibCfg));
    gate(1'b0);
    // Opt-in and opt-out, by enter and resume, left by exit and async exit
    for (int s = 0; s < 4; s++) begin
      oi = s[0];
      slow <= s[0] ^ s[1];
      faultMode <= (s == 1);
      entIp = rnd();
      if (oi) expRec.push_back({1'b0, entIp});
      ret(s[1] ? eps_pkg::RET_RESUME : eps_pkg::RET_ENTER, entIp, oi);
      gate(!oi);
      rd(eps_pkg::ADDR_STATUS, oi ? 64'h0 : 64'h1 << eps_pkg::SCI_FLAG_BIT);
      rd(eps_pkg::ADDR_SESSION, (64'h1 << eps_pkg::SES_IN_BIT) | (64'(oi) << eps_pkg::SES_OPTIN_BIT));
      for (k = eps_pkg::RET_OTHER; k <= eps_pkg::RET_REPORT; k++) begin
        a = rnd();
        if (oi) expRec.push_back({1'b0, a});
        ret(k, a, 1'b0);
      end
      a = rnd();
      b = rnd();
      c = rnd();
      if (s[1]) begin
        ssaIp <= b;
        aepIp <= c;
        expRec.push_back({1'b1, oi ? b : entIp});
        expRec.push_back({1'b0, c});
        ret(eps_pkg::RET_AEX, a, 1'b0);
      end else begin
        expRec.push_back({1'b0, oi ? a : entIp});
        ret(eps_pkg::RET_EXIT, a, 1'b0);
      end
      gate(1'b0);
      wr(eps_pkg::ADDR_STATUS_CLR, 64'h1 << eps_pkg::SCI_FLAG_BIT);
      rd(eps_pkg::ADDR_STATUS, 64'h0);
    end
    repeat (4) @(posedge clk);
    check(65'(expRec.size()), 65'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
